// ==== clk_rst_seq_pkg.sv ====
// Purpose: shared constants for the clock mode and reset sequencer
// Assumes: aclk at 100 MHz
// Notes: register offsets are byte addresses on the AXI4-Lite slave
package clk_rst_seq_pkg;
   localparam int CLK_MHZ = 100;
   // oscillator select encodings
   localparam logic [2:0] OSC_LP = 3'h0;
   localparam logic [2:0] OSC_XT = 3'h1;
   localparam logic [2:0] OSC_HS = 3'h2;
   localparam logic [2:0] OSC_EC = 3'h3;
   localparam logic [2:0] OSC_IRC = 3'h4;
   localparam logic [2:0] OSC_IRC_CO = 3'h5;
   localparam logic [2:0] OSC_ER = 3'h6;
   localparam logic [2:0] OSC_ER_CO = 3'h7;
   // speed change inactive intervals, ns
   localparam int F2S_MIN_NS = 100000;
   localparam int F2S_MAX_NS = 300000;
   localparam int S2F_MIN_NS = 1250;
   localparam int S2F_MAX_NS = 3250;
   localparam int F2S_CYC = (F2S_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int S2F_CYC = (S2F_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int STALL_W = 15;
   // oscillator start-up count on osc_in edges
   localparam int OST_CNT = 1024;
   localparam int OST_W = 11;
   // reset pin noise filter length, ns
   localparam int FILT_NS = 100;
   localparam int FILT_CYC = (FILT_NS * CLK_MHZ) / 1000;
   localparam int FILT_W = 5;
   localparam int PUT_W = 16;
   // register map
   localparam logic [7:0] CFG_ADDR = 8'h00;
   localparam logic [7:0] POWER_CONTROL_REG_ADDR = 8'h04;
   localparam logic [7:0] STAT_ADDR = 8'h08;
   localparam logic [7:0] KEEP_ADDR = 8'h0C;
   // config field positions
   localparam int CFG_OSC_LSB = 0;
   localparam int CFG_POWER_UP_TIMER_ENABLE_BIT = 4;
   localparam int CFG_PINFN = 5;
   localparam logic [5:0] CFG_RST = 6'h20;
   localparam int POWER_CONTROL_REG_CLOCK_SPEED_SELECT = 3;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== clock_mode_and_reset_sequencer.sv ====
// Purpose: clock mode selection, dual-speed switch and reset sequencing
// Assumes: supply, brown-out and watchdog events arrive asynchronous
// Notes: power-up delay counted by internal RC ticks, start-up by osc_in edges
`timescale 1ns/1ps
`default_nettype none
module clock_mode_and_reset_sequencer #(
   parameter logic [15:0] PUT_TICKS = 16'h0048
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic supply_rise,
   input wire logic brownout_reset,
   input wire logic watchdog_reset,
   input wire logic sleep_state,
   input wire logic ext_reset_pin,
   input wire logic osc_in_pin,
   input wire logic put_rc_tick,
   input wire logic fast_osc_clk,
   input wire logic slow_osc_clk,
   output logic sys_reset,
   output logic wake_up,
   output logic cpu_stall,
   output logic sys_clk_run,
   output logic osc_enable,
   output logic slow_sel,
   output logic osc_out_is_gpio,
   output logic osc_out_oe,
   output logic clock_out_pin,
   output logic reset_pin_gpio_in
);
   typedef enum logic [1:0] {
      SQ_RUN = 2'b00,
      SQ_PUT = 2'b01,
      SQ_OST = 2'b10,
      SQ_BOR = 2'b11
   } seq_e;

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   localparam int NS = 8;
   logic [NS-1:0] sync1_ff, sync2_ff, prev_ff;
   logic [NS-1:0] async_in;
   assign async_in = {slow_osc_clk, fast_osc_clk, put_rc_tick, osc_in_pin,
                      ext_reset_pin, sleep_state, watchdog_reset, brownout_reset};
   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++) begin : g_sync
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               sync1_ff[gi] <= 1'b0;
               sync2_ff[gi] <= 1'b0;
               prev_ff[gi] <= 1'b0;
            end else begin
               sync1_ff[gi] <= async_in[gi];
               sync2_ff[gi] <= sync1_ff[gi];
               prev_ff[gi] <= sync2_ff[gi];
            end
         end
      end
   endgenerate
   logic bor_s, wdt_s, slp_s, pin_s, osc_rise, put_rise, fast_rise, slow_rise;
   assign bor_s = sync2_ff[0];
   assign wdt_s = sync2_ff[1] & ~prev_ff[1];
   assign slp_s = sync2_ff[2];
   assign pin_s = sync2_ff[3];
   assign osc_rise = sync2_ff[4] & ~prev_ff[4];
   assign put_rise = sync2_ff[5] & ~prev_ff[5];
   assign fast_rise = sync2_ff[6] & ~prev_ff[6];
   assign slow_rise = sync2_ff[7] & ~prev_ff[7];
   logic por_s1_ff, por_s2_ff, por_prev_ff, por_pulse;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         por_s1_ff <= 1'b0;
         por_s2_ff <= 1'b0;
         por_prev_ff <= 1'b0;
      end else begin
         por_s1_ff <= supply_rise;
         por_s2_ff <= por_s1_ff;
         por_prev_ff <= por_s2_ff;
      end
   end
   assign por_pulse = por_s2_ff & ~por_prev_ff;

   // ----------------------------------------
   // configuration and control registers
   // ----------------------------------------
   logic [5:0] cfg_ff;
   logic clock_speed_select_ff;
   logic [31:0] keep_ff;
   logic [2:0] osc_sel;
   logic crystal, rc_mode, co_mode;
   assign osc_sel = cfg_ff[clk_rst_seq_pkg::CFG_OSC_LSB +: 3];
   assign crystal = (osc_sel == clk_rst_seq_pkg::OSC_LP) || (osc_sel == clk_rst_seq_pkg::OSC_XT)
                    || (osc_sel == clk_rst_seq_pkg::OSC_HS);
   assign rc_mode = osc_sel[2];
   assign co_mode = rc_mode & osc_sel[0];

   // ----------------------------------------
   // reset pin noise filter
   // ----------------------------------------
   logic [4:0] filt_ff;
   logic pin_rst_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         filt_ff <= 5'h00;
         pin_rst_ff <= 1'b0;
      end else if (!cfg_ff[clk_rst_seq_pkg::CFG_PINFN] || pin_s) begin
         filt_ff <= 5'h00;
         pin_rst_ff <= 1'b0;
      end else if (filt_ff == 5'(clk_rst_seq_pkg::FILT_CYC)) begin
         pin_rst_ff <= 1'b1;
      end else begin
         filt_ff <= filt_ff + 5'h01;
      end
   end

   // ----------------------------------------
   // time-out sequence
   // ----------------------------------------
   seq_e seq_ff;
   logic [15:0] put_ff;
   logic [10:0] ost_ff;
   logic wdt_rst_ff, wake_ff, ost_wake_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seq_ff <= SQ_RUN;
         put_ff <= 16'h0000;
         ost_ff <= 11'h000;
         ost_wake_ff <= 1'b0;
      end else begin
         case (seq_ff)
            SQ_RUN: begin
               ost_wake_ff <= 1'b0;
               if (bor_s) begin
                  seq_ff <= SQ_BOR;
               end else if (por_pulse) begin
                  put_ff <= 16'h0000;
                  ost_ff <= 11'h000;
                  seq_ff <= cfg_ff[clk_rst_seq_pkg::CFG_POWER_UP_TIMER_ENABLE_BIT] ? (crystal ? SQ_OST : SQ_RUN)
                                                               : SQ_PUT;
               end else if (slp_s && wdt_s && crystal) begin
                  ost_ff <= 11'h000;
                  ost_wake_ff <= 1'b1;
                  seq_ff <= SQ_OST;
               end
            end
            SQ_BOR: begin
               put_ff <= 16'h0000;
               if (!bor_s) begin
                  seq_ff <= SQ_PUT;
               end
            end
            SQ_PUT: begin
               if (bor_s) begin
                  seq_ff <= SQ_BOR;
               end else if (put_ff == PUT_TICKS) begin
                  ost_ff <= 11'h000;
                  seq_ff <= crystal ? SQ_OST : SQ_RUN;
               end else if (put_rise) begin
                  put_ff <= put_ff + 16'h0001;
               end
            end
            SQ_OST: begin
               if (bor_s) begin
                  ost_wake_ff <= 1'b0;
                  seq_ff <= SQ_BOR;
               end else if (ost_ff == 11'(clk_rst_seq_pkg::OST_CNT)) begin
                  seq_ff <= SQ_RUN;
               end else if (osc_rise) begin
                  ost_ff <= ost_ff + 11'h001;
               end
            end
            default: seq_ff <= SQ_RUN;
         endcase
      end
   end

   // watchdog: reset when awake, wake-up when asleep; pin never driven
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdt_rst_ff <= 1'b0;
         wake_ff <= 1'b0;
      end else begin
         wdt_rst_ff <= wdt_s & ~slp_s;
         wake_ff <= wdt_s & slp_s;
      end
   end
   logic pwr_rst, any_rst;
   assign pwr_rst = (seq_ff != SQ_RUN) & ~ost_wake_ff;
   assign any_rst = pwr_rst | pin_rst_ff | wdt_rst_ff;

   // ----------------------------------------
   // dual speed switch
   // ----------------------------------------
   logic [14:0] stall_ff;
   logic speed_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn || any_rst) begin
         stall_ff <= 15'h0000;
         speed_ff <= 1'b1;
      end else if (stall_ff != 15'h0000) begin
         stall_ff <= stall_ff - 15'h0001;
      end else if (rc_mode && (clock_speed_select_ff != speed_ff)) begin
         speed_ff <= clock_speed_select_ff;
         stall_ff <= clock_speed_select_ff ? 15'(clk_rst_seq_pkg::S2F_CYC)
                             : 15'(clk_rst_seq_pkg::F2S_CYC);
      end
   end

   // ----------------------------------------
   // clock output divider and pin outputs
   // ----------------------------------------
   logic [1:0] div_ff;
   logic osc_edge;
   // slow source is its own fixed oscillator, not the resistor one
   assign osc_edge = speed_ff ? fast_rise : slow_rise;
   always_ff @(posedge aclk) begin
      if (!aresetn || any_rst) begin
         div_ff <= 2'h0;
         clock_out_pin <= 1'b0;
      end else if (co_mode && osc_edge) begin
         div_ff <= div_ff + 2'h1;
         clock_out_pin <= (div_ff == 2'h1) ? 1'b1 :
                          (div_ff == 2'h3) ? 1'b0 : clock_out_pin;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sys_reset <= 1'b1;
         wake_up <= 1'b0;
         cpu_stall <= 1'b0;
         sys_clk_run <= 1'b0;
         osc_enable <= 1'b0;
         slow_sel <= 1'b0;
         osc_out_is_gpio <= 1'b0;
         osc_out_oe <= 1'b0;
         reset_pin_gpio_in <= 1'b0;
      end else begin
         sys_reset <= any_rst;
         wake_up <= wake_ff;
         cpu_stall <= stall_ff != 15'h0000;
         sys_clk_run <= ~any_rst & (stall_ff == 15'h0000);
         osc_enable <= ~(rc_mode & any_rst);
         slow_sel <= rc_mode & ~speed_ff;
         osc_out_is_gpio <= (osc_sel == clk_rst_seq_pkg::OSC_EC)
                            || (rc_mode && !co_mode);
         osc_out_oe <= co_mode;
         reset_pin_gpio_in <= ~cfg_ff[clk_rst_seq_pkg::CFG_PINFN] & pin_s;
      end
   end

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   logic [7:0] awa_ff;
   logic [31:0] wd_ff;
   logic [3:0] ws_ff;
   logic aw_ok_ff, w_ok_ff;
   logic aw_hit;
   assign aw_hit = (awa_ff == clk_rst_seq_pkg::CFG_ADDR)
                   || (awa_ff == clk_rst_seq_pkg::POWER_CONTROL_REG_ADDR)
                   || (awa_ff == clk_rst_seq_pkg::STAT_ADDR)
                   || (awa_ff == clk_rst_seq_pkg::KEEP_ADDR);
   assign s_axi_awready = aresetn & ~aw_ok_ff & ~s_axi_bvalid;
   assign s_axi_wready = aresetn & ~w_ok_ff & ~s_axi_bvalid;
   assign s_axi_arready = aresetn & ~s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok_ff <= 1'b0;
         w_ok_ff <= 1'b0;
         awa_ff <= 8'h00;
         wd_ff <= 32'h0000_0000;
         ws_ff <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= clk_rst_seq_pkg::RESP_OK;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_ff <= 1'b1;
            awa_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok_ff <= 1'b1;
            wd_ff <= s_axi_wdata;
            ws_ff <= s_axi_wstrb;
         end
         if (aw_ok_ff && w_ok_ff) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= aw_hit ? clk_rst_seq_pkg::RESP_OK : clk_rst_seq_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   logic wr_go;
   assign wr_go = aw_ok_ff & w_ok_ff;
   // configuration is loaded by aresetn only; supply, brown-out, pin and watchdog resets keep it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_ff <= clk_rst_seq_pkg::CFG_RST;
      end else if (wr_go && awa_ff == clk_rst_seq_pkg::CFG_ADDR && ws_ff[0]) begin
         cfg_ff <= wd_ff[5:0];
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || any_rst) begin
         clock_speed_select_ff <= 1'b1;
      end else if (wr_go && awa_ff == clk_rst_seq_pkg::POWER_CONTROL_REG_ADDR && ws_ff[0]) begin
         clock_speed_select_ff <= wd_ff[clk_rst_seq_pkg::POWER_CONTROL_REG_CLOCK_SPEED_SELECT];
      end
   end
   // unaffected scratch word: no reset term, kept through all resets
   always_ff @(posedge aclk) begin
      if (wr_go && awa_ff == clk_rst_seq_pkg::KEEP_ADDR) begin
         for (int b = 0; b < 4; b++) begin
            if (ws_ff[b]) begin
               keep_ff[b*8 +: 8] <= wd_ff[b*8 +: 8];
            end
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= clk_rst_seq_pkg::RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= clk_rst_seq_pkg::RESP_OK;
         case (s_axi_araddr)
            clk_rst_seq_pkg::CFG_ADDR: s_axi_rdata <= {26'h0, cfg_ff};
            clk_rst_seq_pkg::POWER_CONTROL_REG_ADDR: s_axi_rdata <= {28'h0, clock_speed_select_ff, 3'h0};
            clk_rst_seq_pkg::STAT_ADDR: s_axi_rdata <= {25'h0, wake_ff, wdt_rst_ff, pin_rst_ff,
                                                        cpu_stall, speed_ff, seq_ff};
            clk_rst_seq_pkg::KEEP_ADDR: s_axi_rdata <= keep_ff;
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= clk_rst_seq_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== clock_mode_and_reset_sequencer_sva.sv ====
// Purpose: port checks for the clock mode and reset sequencer
// Assumes: bound to the top module, one clock domain
// Notes: stall lengths are measured by a helper counter
`timescale 1ns/1ps
`default_nettype none
module clock_mode_and_reset_sequencer_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic brownout_reset,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic sys_reset,
   input wire logic wake_up,
   input wire logic cpu_stall,
   input wire logic sys_clk_run,
   input wire logic osc_enable,
   input wire logic slow_sel,
   input wire logic osc_out_is_gpio,
   input wire logic osc_out_oe,
   input wire logic clock_out_pin
);
   localparam int S2F_LO = clk_rst_seq_pkg::S2F_CYC;
   localparam int S2F_HI = clk_rst_seq_pkg::S2F_MAX_NS * clk_rst_seq_pkg::CLK_MHZ / 1000;
   localparam int F2S_LO = clk_rst_seq_pkg::F2S_CYC;
   localparam int F2S_HI = clk_rst_seq_pkg::F2S_MAX_NS * clk_rst_seq_pkg::CLK_MHZ / 1000;
   logic [15:0] stall_cnt_ff;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----------------------------------------
   // stall length counter
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn || !cpu_stall) begin
         stall_cnt_ff <= 16'h0000;
      end else begin
         stall_cnt_ff <= stall_cnt_ff + 16'h0001;
      end
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   reset_vals_a: assert property (disable iff (1'b0)
      !aresetn |=> sys_reset && !cpu_stall && !slow_sel && !clock_out_pin)
      else $error("outputs wrong during reset");
   brownout_hold_a: assert property (brownout_reset [*6] |-> sys_reset)
      else $error("brown-out did not hold reset");
   clock_out_pin_low_a: assert property (sys_reset [*2] |-> !clock_out_pin)
      else $error("clock out not low in reset");
   osc_halt_a: assert property ((osc_out_oe && sys_reset) [*3] |-> !osc_enable)
      else $error("oscillator running in reset");
   pin_role_a: assert property (osc_out_oe |-> !osc_out_is_gpio)
      else $error("pin both clock out and io");
   stall_gate_a: assert property (cpu_stall [*2] |-> !sys_clk_run)
      else $error("clock runs during stall");
   stall_len_a: assert property ($fell(cpu_stall) |->
      (stall_cnt_ff >= S2F_LO && stall_cnt_ff <= S2F_HI) ||
      (stall_cnt_ff >= F2S_LO && stall_cnt_ff <= F2S_HI))
      else $error("stall length out of range");
   wake_run_a: assert property (wake_up |-> !sys_reset)
      else $error("wake-up came with reset");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   cover property ($fell(cpu_stall));
   cover property (wake_up);
   cover property ((osc_out_oe && sys_reset) [*3]);
endmodule
`default_nettype wire

// ==== clock_mode_and_reset_sequencer_tb.sv ====
// Purpose: self-checking bench for the clock mode and reset sequencer
// Assumes: power-up delay cut to 4 ticks, one tick every 8 cycles
// Notes: osc_in and fast oscillator toggle every 2 cycles
`timescale 1ns/1ps
`default_nettype none
module clock_mode_and_reset_sequencer_tb;
   localparam logic [7:0] CFG = clk_rst_seq_pkg::CFG_ADDR;
   localparam logic [7:0] POWER_CONTROL_REG = clk_rst_seq_pkg::POWER_CONTROL_REG_ADDR;
   localparam logic [7:0] KEEP = clk_rst_seq_pkg::KEEP_ADDR;
   logic aclk = 1'b0, aresetn = 1'b0, supply_rise = 1'b0, brownout_reset = 1'b0;
   logic watchdog_reset = 1'b0, sleep_state = 1'b0, ext_reset_pin = 1'b1;
   logic osc_in_pin = 1'b0, put_rc_tick = 1'b0, fast_osc_clk = 1'b0, slow_osc_clk = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, cyc = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, rd, cv;
   logic sys_reset, wake_up, cpu_stall, sys_clk_run, osc_enable, slow_sel;
   logic osc_out_is_gpio, osc_out_oe, clock_out_pin, reset_pin_gpio_in, pc, pf;
   int fails = 0;
   int tests_run = 0;
   int n, m;
   // osc select, expected io role, expected clock out role
   logic [4:0] rows [8] = '{5'b000_0_0, 5'b001_0_0, 5'b010_0_0, 5'b011_1_0,
      5'b100_1_0, 5'b101_0_1, 5'b110_1_0, 5'b111_0_1};
   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 8'h01;
      osc_in_pin <= cyc[1];
      fast_osc_clk <= cyc[1];
      put_rc_tick <= cyc[2];
      slow_osc_clk <= cyc[6];
   end
   clock_mode_and_reset_sequencer #(.PUT_TICKS(16'h0004)) clock_mode_and_reset_sequencer_inst (.*);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         fails++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task automatic guard(input int k, input int lim);
      if (k > lim) begin
         chk(1'b0, "wait ran out");
         final_report();
      end
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: return cpu_stall;
         1: return sys_reset;
         default: return wake_up;
      endcase
   endfunction
   // cycles until the chosen output shows v
   task automatic wt(input int s, input logic v, input int lim, input bit must, output int k);
      k = 0;
      do begin
         @(negedge aclk);
         k++;
      end while (sig(s) !== v && k <= lim);
      if (must) guard(k, lim);
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      @(posedge aclk);
      k = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         guard(k, 50);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      @(posedge aclk);
      k = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         guard(k, 50);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(CFG, rd, rsp);
      chk(rd === 32'h0000_0020, "config reset value");
      axi_rd(POWER_CONTROL_REG, rd, rsp);
      chk(rd[clk_rst_seq_pkg::POWER_CONTROL_REG_CLOCK_SPEED_SELECT] === 1'b1 && slow_sel === 1'b0, "speed reset");
      axi_rd(8'h10, rd, rsp);
      chk(rsp === clk_rst_seq_pkg::RESP_SLVERR, "unmapped read");
      axi_wr(8'h14, 32'h0000_0001, rsp);
      chk(rsp === clk_rst_seq_pkg::RESP_SLVERR, "unmapped write");
      $display("test reset done");
      foreach (rows[i]) begin
         cv = {26'h0, 3'b110, rows[i][4:2]};
         axi_wr(CFG, cv, rsp);
         repeat (4) @(negedge aclk);
         chk({osc_out_is_gpio, osc_out_oe} === rows[i][1:0], "pin role");
         axi_rd(CFG, rd, rsp);
         chk(rd === cv, "config readback");
      end
      $display("test modes done");
      axi_wr(CFG, 32'h0000_0035, rsp);
      axi_wr(POWER_CONTROL_REG, 32'h0000_0000, rsp);
      wt(0, 1'b1, 20, 1, n);
      wt(0, 1'b0, 40000, 1, n);
      chk(n >= 9995 && n <= 30000 && slow_sel === 1'b1, "fast to slow");
      axi_wr(POWER_CONTROL_REG, 32'h0000_0008, rsp);
      wt(0, 1'b1, 20, 1, n);
      wt(0, 1'b0, 400, 1, n);
      chk(n >= 120 && n <= 325 && slow_sel === 1'b0, "slow to fast");
      $display("test speed done");
      n = 0;
      m = 0;
      for (int i = 0; i < 320; i++) begin
         pc = clock_out_pin;
         pf = fast_osc_clk;
         @(negedge aclk);
         if (clock_out_pin === 1'b1 && pc === 1'b0) n++;
         if (fast_osc_clk === 1'b1 && pf === 1'b0) m++;
      end
      chk(n * 4 >= m - 4 && n * 4 <= m + 4 && n > 0, "clock out rate");
      $display("test clock out done");
      @(posedge aclk);
      brownout_reset <= 1'b1;
      repeat (10) @(posedge aclk);
      brownout_reset <= 1'b0;
      repeat (12) @(posedge aclk);
      brownout_reset <= 1'b1;
      repeat (10) @(posedge aclk);
      brownout_reset <= 1'b0;
      wt(1, 1'b0, 200, 1, n);
      chk(n >= 24 && n <= 50, "brown-out delay");
      @(posedge aclk);
      supply_rise <= 1'b1;
      wt(1, 1'b1, 10, 0, n);
      wt(1, 1'b0, 20, 1, m);
      chk(m <= 8, "rc power-on without delay");
      @(posedge aclk);
      supply_rise <= 1'b0;
      $display("test power rc done");
      ext_reset_pin <= 1'b0;
      repeat (5) @(posedge aclk);
      ext_reset_pin <= 1'b1;
      wt(1, 1'b1, 20, 0, n);
      chk(n > 20, "short pin pulse");
      @(posedge aclk);
      ext_reset_pin <= 1'b0;
      wt(1, 1'b1, 20, 1, n);
      @(posedge aclk);
      ext_reset_pin <= 1'b1;
      wt(1, 1'b0, 50, 1, n);
      chk(n <= 20, "pin reset release");
      axi_wr(CFG, 32'h0000_0015, rsp);
      ext_reset_pin <= 1'b0;
      wt(1, 1'b1, 20, 0, n);
      chk(n > 20 && reset_pin_gpio_in === 1'b0, "pin as input");
      @(posedge aclk);
      ext_reset_pin <= 1'b1;
      repeat (4) @(negedge aclk);
      chk(reset_pin_gpio_in === 1'b1 && sys_reset === 1'b0, "pin input high");
      $display("test pin done");
      axi_wr(CFG, 32'h0000_0035, rsp);
      axi_wr(KEEP, 32'h5A5A_A5A5, rsp);
      watchdog_reset <= 1'b1;
      wt(1, 1'b1, 10, 1, n);
      @(posedge aclk);
      watchdog_reset <= 1'b0;
      wt(1, 1'b0, 50, 1, n);
      axi_rd(KEEP, rd, rsp);
      chk(rd === 32'h5A5A_A5A5, "kept word");
      axi_rd(CFG, rd, rsp);
      chk(rd === 32'h0000_0035, "config kept");
      axi_wr(CFG, 32'h0000_0031, rsp);
      sleep_state <= 1'b1;
      repeat (3) @(posedge aclk);
      watchdog_reset <= 1'b1;
      wt(2, 1'b1, 10, 1, n);
      chk(sys_reset === 1'b0, "sleep timeout wakes");
      @(posedge aclk);
      watchdog_reset <= 1'b0;
      sleep_state <= 1'b0;
      axi_rd(clk_rst_seq_pkg::STAT_ADDR, rd, rsp);
      chk(rd[1:0] === 2'h2 && sys_reset === 1'b0, "wake start-up count");
      repeat (4200) @(posedge aclk);
      axi_rd(clk_rst_seq_pkg::STAT_ADDR, rd, rsp);
      chk(rd[1:0] === 2'h0 && sys_reset === 1'b0, "wake start-up done");
      $display("test watchdog done");
      axi_wr(CFG, 32'h0000_0021, rsp);
      supply_rise <= 1'b1;
      wt(1, 1'b1, 10, 1, n);
      wt(1, 1'b0, 6000, 1, n);
      chk(n >= 4110 && n <= 4160, "crystal power-up hold");
      @(posedge aclk);
      supply_rise <= 1'b0;
      aresetn <= 1'b0;
      repeat (2) @(negedge aclk);
      chk(sys_reset === 1'b1 && cpu_stall === 1'b0, "second reset");
      @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(CFG, rd, rsp);
      chk(rd === 32'h0000_0020, "config after second reset");
      $display("test power crystal done");
      final_report();
   end
endmodule
bind clock_mode_and_reset_sequencer clock_mode_and_reset_sequencer_sva
   clock_mode_and_reset_sequencer_sva_inst (.*);
`default_nettype wire
